// file: hw/tss_consts.svh
// constants for the thermocouple scan sequencer
//
// Functional notes
// - each conversion cycle converts every enabled channel with sensor code 1-4, 6 or 7 and skips the rest
// - model 0 adds a terminal temperature slot per cycle; model 1 omits it
// - model 0 cycle lasts (n+1) times (2 x filter time + 200 us)
// - model 1 cycle lasts n times (2 x filter time + 200 us)
// - model 1 with one enabled channel: cycle equals filter time alone
// - one 3-bit filter code sets filter time for all inputs, 66.7 to 1 ms
// - sensor codes 1-4 pick J, K, S, N handling; 0 and 5 disable conversion
// - codes 6 and 7 give raw microvolts, 1 uV or 2 uV steps, uncompensated
// - per-channel enable bit, resets to on; disabling shortens the cycle
// - two-bit status per channel packed into low and high status bytes
// - any change of a channel status raises an error message to the controller
// - faults substitute the value: 7FFF high or break, 8001 low, 8000 invalid
// - update counter increments once after all input values are refreshed
// - fresh data comes no faster than the per-model update interval
// - controller may write a reference temperature per channel; mode is module wide
// - external mode adds each channel's supplied reference temperature
// - internally measured compensation temperature is readable
// - channels may be disabled and re-enabled; scan adapts on the fly
// - fixed read-only module identification code
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
// timing
`define TSS_CLK_NS 50
`define TSS_OVH_US 200
`define TSS_OVH_CYC (`TSS_OVH_US * 1000 / `TSS_CLK_NS)
`define TSS_FT0_US 66700
`define TSS_FT1_US 40000
`define TSS_FT2_US 33300
`define TSS_FT3_US 20000
`define TSS_FT4_US 16700
`define TSS_FT5_US 10000
`define TSS_FT6_US 2000
`define TSS_FT7_US 1000
// register byte offsets
`define TSS_A_CTRL 8'h00
`define TSS_A_ENA 8'h04
`define TSS_A_TYPE 8'h08
`define TSS_A_STLO 8'h0C
`define TSS_A_STHI 8'h10
`define TSS_A_CNT 8'h14
`define TSS_A_ERR 8'h18
`define TSS_A_ID 8'h1C
`define TSS_A_TERM 8'h20
`define TSS_A_REF 3'b010
`define TSS_A_VAL 3'b011
// fields and reset values
`define TSS_CTRL_MODEL 3
`define TSS_CTRL_EXT 4
`define TSS_ENA_RST 6'h3F
`define TSS_TYPE_RST 18'h0_9249
`define TSS_ST_OFF0 3'd0
`define TSS_ST_J 3'd1
`define TSS_ST_K 3'd2
`define TSS_ST_S 3'd3
`define TSS_ST_N 3'd4
`define TSS_ST_OFF5 3'd5
`define TSS_ST_RAW1 3'd6
`define TSS_ST_RAW2 3'd7
`define TSS_G_J 32'h0000_0031
`define TSS_G_K 32'h0000_003E
`define TSS_G_S 32'h0000_0100
`define TSS_G_N 32'h0000_0043
`define TSS_V_HI 16'h7FFF
`define TSS_V_LO 16'h8001
`define TSS_V_INV 16'h8000
`define TSS_S_OK 2'b00
`define TSS_S_LO 2'b01
`define TSS_S_HI 2'b10
`define TSS_S_BRK 2'b11
`define TSS_TERM_SLOT 3'd6
`define TSS_NO_SLOT 3'd7
`endif

// file: hw/tss_pkg.sv
// types for the thermocouple scan sequencer
package tss_pkg;
  typedef enum logic [3:0] {
    tss_idle = 4'b0001,
    tss_launch = 4'b0010,
    tss_wait = 4'b0100,
    tss_store = 4'b1000
  } tss_state_t;
endpackage

// file: hw/tss_top.sv
// thermocouple scan sequencer with ahb-lite register slave
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tss_consts.svh"
module tss_top #(
  parameter logic [15:0] ID_CODE = 16'h5A3C, // arbitrary value
  parameter logic [7:0][23:0] FILT_CYC = {
    24'(`TSS_FT7_US * 1000 / `TSS_CLK_NS),
    24'(`TSS_FT6_US * 1000 / `TSS_CLK_NS),
    24'(`TSS_FT5_US * 1000 / `TSS_CLK_NS),
    24'(`TSS_FT4_US * 1000 / `TSS_CLK_NS),
    24'(`TSS_FT3_US * 1000 / `TSS_CLK_NS),
    24'(`TSS_FT2_US * 1000 / `TSS_CLK_NS),
    24'(`TSS_FT1_US * 1000 / `TSS_CLK_NS),
    24'(`TSS_FT0_US * 1000 / `TSS_CLK_NS)
  },
  parameter logic [23:0] OVH_CYC = 24'(`TSS_OVH_CYC)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic conv_start,
  output logic [2:0] conv_sel,
  input wire logic conv_done,
  input wire logic signed [17:0] conv_data,
  input wire logic conv_break,
  input wire logic conv_invalid,
  output logic error_msg
);

  // ****************************************
  // functions
  // ****************************************

  // lowest active slot at or above the given one, or none
  function automatic logic [2:0] next_slot(input logic [6:0] m, input logic [3:0] from);
    logic [2:0] r;
    r = `TSS_NO_SLOT;
    for (int i = 6; i >= 0; i--) begin
      if (m[i] && (4'(i) >= from)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // converts a sample to {status, value} with limit substitution
  function automatic logic [17:0] convert(input logic [2:0] typ,
                                          input logic signed [17:0] s,
                                          input logic signed [15:0] ref_t);
    logic signed [31:0] t;
    logic signed [31:0] g;
    t = 32'(s);
    g = `TSS_G_K;
    case (typ)
      `TSS_ST_J: g = `TSS_G_J;
      `TSS_ST_S: g = `TSS_G_S;
      `TSS_ST_N: g = `TSS_G_N;
      default: g = `TSS_G_K;
    endcase
    if (typ == `TSS_ST_RAW2) begin
      t = t >>> 1; // 2 uV per step, no compensation
    end else if (typ != `TSS_ST_RAW1) begin
      t = ((t * g) >>> 8) + 32'(ref_t); // linearise plus junction
    end
    if (t > 32'sd32767) begin
      return {`TSS_S_HI, `TSS_V_HI};
    end else if (t < -32'sd32767) begin
      return {`TSS_S_LO, `TSS_V_LO};
    end
    return {`TSS_S_OK, t[15:0]};
  endfunction

  // ****************************************
  // configuration and status registers
  // ****************************************

  logic [2:0] filt;
  logic model1;
  logic ext_ref;
  logic [5:0] ena;
  logic [17:0] types;
  logic [15:0] ref_temp [6];
  logic [15:0] value [6];
  logic [1:0] status [6];
  logic [15:0] term_temp;
  logic [7:0] update_cycle_counter;
  logic err;

  // ****************************************
  // ahb-lite slave
  // ****************************************

  logic ap;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] rdv;
  logic err_clr;
  logic [7:0] ra;

  assign ap = hsel & htrans[1] & hready;
  assign ra = haddr[7:0];
  assign err_clr = wr_pend && (wr_addr == `TSS_A_ERR) && hwdata[0];

  // a write lands in its data phase, one edge after the address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= ap & hwrite & (hsize == 3'b010);
      wr_addr <= ra;
    end
  end

  // zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdv = 32'h0000_0000;
    case (ra)
      `TSS_A_CTRL: rdv = {27'h0, ext_ref, model1, filt};
      `TSS_A_ENA: rdv = {26'h0, ena};
      `TSS_A_TYPE: rdv = {14'h0, types};
      `TSS_A_STLO: rdv = {24'h0, status[3], status[2], status[1], status[0]};
      `TSS_A_STHI: rdv = {28'h0, status[5], status[4]};
      `TSS_A_CNT: rdv = {24'h0, update_cycle_counter};
      `TSS_A_ERR: rdv = {31'h0, err};
      `TSS_A_ID: rdv = {16'h0, ID_CODE};
      `TSS_A_TERM: rdv = {16'h0, term_temp};
      default: begin
        if (ra[7:5] == `TSS_A_REF && ra[4:2] < 3'd6) begin
          rdv = {16'h0, ref_temp[ra[4:2]]};
        end else if (ra[7:5] == `TSS_A_VAL && ra[4:2] < 3'd6) begin
          rdv = {16'h0, value[ra[4:2]]};
        end
      end
    endcase
  end

  // read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap && !hwrite) begin
      hrdata <= rdv;
    end
  end

  // control writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt <= 3'd0;
      model1 <= 1'b0;
      ext_ref <= 1'b0;
      ena <= `TSS_ENA_RST;
      types <= `TSS_TYPE_RST;
    end else if (wr_pend) begin
      case (wr_addr)
        `TSS_A_CTRL: begin
          filt <= hwdata[2:0];
          model1 <= hwdata[`TSS_CTRL_MODEL];
          ext_ref <= hwdata[`TSS_CTRL_EXT]; // one bit for all channels
        end
        `TSS_A_ENA: ena <= hwdata[5:0];
        `TSS_A_TYPE: types <= hwdata[17:0];
        default: ;
      endcase
    end
  end

  // reference junction temperatures per channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 6; i++) begin
        ref_temp[i] <= 16'h0000;
      end
    end else if (wr_pend && wr_addr[7:5] == `TSS_A_REF && wr_addr[4:2] < 3'd6) begin
      ref_temp[wr_addr[4:2]] <= hwdata[15:0];
    end
  end

  // ****************************************
  // scan sequencer
  // ****************************************

  tss_pkg::tss_state_t state;
  logic [2:0] slot;
  logic [23:0] tmr;
  logic [6:0] m;
  logic [5:0] act;
  logic [23:0] ft;
  logic [23:0] slot_cyc;
  logic signed [17:0] smp;
  logic got;
  logic brk;
  logic inv;
  logic [2:0] first;
  logic [2:0] after;
  logic [2:0] styp;
  logic [17:0] res;
  logic [15:0] jref;
  logic chg;

  // a channel counts when enabled and its type converts
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      styp = types[3 * i +: 3];
      act[i] = ena[i] && (styp != `TSS_ST_OFF0) && (styp != `TSS_ST_OFF5);
    end
    styp = types[3 * slot +: 3];
  end

  assign m = {~model1, act}; // terminal slot only in model 0
  assign first = next_slot(m, 4'd0);
  assign after = next_slot(m, 4'(slot) + 4'd1);
  assign ft = FILT_CYC[filt];

  // slot wait: 2 x filter + overhead, or the filter alone when model 1 has one active channel
  always_comb begin
    if (model1 && $onehot(act)) begin
      slot_cyc = ft;
    end else begin
      slot_cyc = 24'(2 * ft + OVH_CYC);
    end
  end

  // raw channels skip compensation inside convert
  assign jref = ext_ref ? ref_temp[slot] : term_temp;
  assign res = convert(styp, smp, jref);

  // state walk; the mask is re-read at each slot boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= tss_pkg::tss_idle;
      slot <= 3'd0;
      tmr <= 24'h00_0000;
    end else begin
      case (state)
        tss_pkg::tss_idle: begin
          if (first != `TSS_NO_SLOT) begin
            slot <= first;
            state <= tss_pkg::tss_launch;
          end
        end
        tss_pkg::tss_launch: begin
          tmr <= slot_cyc - 24'd1;
          state <= tss_pkg::tss_wait;
        end
        tss_pkg::tss_wait: begin
          if (tmr == 24'd0) begin
            state <= tss_pkg::tss_store;
          end else begin
            tmr <= tmr - 24'd1;
          end
        end
        tss_pkg::tss_store: begin
          if (after == `TSS_NO_SLOT) begin
            state <= tss_pkg::tss_idle;
          end else begin
            slot <= after;
            state <= tss_pkg::tss_launch;
          end
        end
        default: state <= tss_pkg::tss_idle;
      endcase
    end
  end

  // front-end request, one cycle per slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_start <= 1'b0;
      conv_sel <= 3'd0;
    end else begin
      conv_start <= (state == tss_pkg::tss_launch);
      if (state == tss_pkg::tss_launch) begin
        conv_sel <= slot;
      end
    end
  end

  // latch the sample; a channel slot without one reads as invalid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp <= 18'sd0;
      got <= 1'b0;
      brk <= 1'b0;
      inv <= 1'b0;
    end else if (state == tss_pkg::tss_launch) begin
      got <= 1'b0;
    end else if (state == tss_pkg::tss_wait && conv_done) begin
      smp <= conv_data;
      got <= 1'b1;
      brk <= conv_break;
      inv <= conv_invalid;
    end
  end

  // results; a slot whose channel went off meanwhile is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 6; i++) begin
        value[i] <= 16'h0000;
        status[i] <= `TSS_S_OK;
      end
      term_temp <= 16'h0000;
    end else if (state == tss_pkg::tss_store) begin
      if (slot == `TSS_TERM_SLOT) begin
        if (got && !inv) begin
          term_temp <= smp[15:0];
        end
      end else if (m[slot]) begin
        if (got && brk) begin
          value[slot] <= `TSS_V_HI;
          status[slot] <= `TSS_S_BRK;
        end else if (!got || inv) begin
          value[slot] <= `TSS_V_INV;
          status[slot] <= `TSS_S_OK;
        end else begin
          value[slot] <= res[15:0];
          status[slot] <= res[17:16];
        end
      end
    end
  end

  // status change detection for the error message
  always_comb begin
    chg = 1'b0;
    if (state == tss_pkg::tss_store && slot != `TSS_TERM_SLOT && m[slot]) begin
      if (got && brk) begin
        chg = (status[slot] != `TSS_S_BRK);
      end else if (!got || inv) begin
        chg = (status[slot] != `TSS_S_OK);
      end else begin
        chg = (status[slot] != res[17:16]);
      end
    end
  end

  // sticky error message; a new change wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err <= 1'b0;
      error_msg <= 1'b0;
    end else begin
      err <= chg | (err & ~err_clr);
      error_msg <= chg | (err & ~err_clr);
    end
  end

  // one count per finished cycle, on the same edge that stores the last slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      update_cycle_counter <= 8'h00;
    end else if (state == tss_pkg::tss_store && after == `TSS_NO_SLOT) begin
      update_cycle_counter <= update_cycle_counter + 8'h01;
    end
  end

endmodule
`default_nettype wire

// file: verification/tss_top_props.sv
// port assertions for the thermocouple scan sequencer
`timescale 1ns/100ps
`default_nettype none
module tss_top_chk #(
  parameter logic [7:0][23:0] FILT_CYC = {8{24'h00_0014}},
  parameter logic [23:0] OVH_CYC = 24'h00_0004
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic conv_start,
  input wire logic [2:0] conv_sel,
  input wire logic error_msg
);
  // ****************************************
  // slot timing and register bus checks
  // ****************************************
  // longest slot plus launch, store and idle; code 0 is taken as the slowest filter
  localparam int GAP_HI = 2 * int'(FILT_CYC[0]) + int'(OVH_CYC) + 8;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a launch and the quiet stretch that must follow it
  sequence s_launch;
    conv_start;
  endsequence
  sequence s_quiet;
    !conv_start [*8];
  endsequence
  property p_pulse;
    s_launch |=> s_quiet;
  endproperty
  property p_sel;
    s_launch |-> conv_sel <= 3'h6;
  endproperty
  property p_sel_hold;
    s_launch |=> $stable(conv_sel) [*8];
  endproperty
  property p_next;
    s_launch |-> ##[8:GAP_HI] conv_start;
  endproperty
  property p_ready;
    $past(hresetn) |-> hreadyout;
  endproperty
  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_rdata;
    !$past(hsel && htrans[1] && !hwrite) |-> $stable(hrdata);
  endproperty
  property p_err_clear;
    $fell(error_msg) |-> $past(hwdata[0]) || $past(hwdata[0], 2);
  endproperty
  a_pulse: assert property (p_pulse) else $error("conversion starts too close");
  a_sel: assert property (p_sel) else $error("slot number out of range");
  a_sel_hold: assert property (p_sel_hold) else $error("slot changed while converting");
  a_next: assert property (p_next) else $error("scan stalled between slots");
  a_ready: assert property (p_ready) else $error("wait state inserted");
  a_okay: assert property (p_okay) else $error("error response given");
  a_rdata: assert property (p_rdata) else $error("read data moved without a read");
  a_err_clear: assert property (p_err_clear) else $error("error message dropped unasked");
endmodule
bind tss_top tss_top_chk #(.FILT_CYC(FILT_CYC), .OVH_CYC(OVH_CYC)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .conv_start(conv_start), .conv_sel(conv_sel), .error_msg(error_msg));
`default_nettype wire

// file: verification/tss_front_model.sv
// converter front end model answering slot requests
`timescale 1ns/100ps
`default_nettype none
module tss_front_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic conv_start,
  input wire logic [2:0] conv_sel,
  input wire logic [7:0] lat,
  output logic conv_done,
  output logic signed [17:0] conv_data,
  output logic conv_break,
  output logic conv_invalid
);
  // ****************************************
  // per-slot samples, set by the bench
  // ****************************************
  logic signed [17:0] samp [7];
  logic brk [7];
  logic inv [7];
  logic [7:0] cnt;
  logic [2:0] sel;
  initial begin
    for (int i = 0; i < 7; i++) begin
      samp[i] = 18'h0_0064;
      brk[i] = 1'b0;
      inv[i] = 1'b0;
    end
  end
  // answer lat cycles after a start; data toggles outside the answer so stale values never pass
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 8'h00;
      sel <= 3'h0;
      conv_done <= 1'b0;
      conv_data <= 18'h2_AAAA;
      conv_break <= 1'b0;
      conv_invalid <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        cnt <= lat;
        sel <= conv_sel;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      if (cnt == 8'h01 && !conv_start) begin
        conv_done <= 1'b1;
        conv_data <= samp[sel];
        conv_break <= brk[sel];
        conv_invalid <= inv[sel];
      end else begin
        conv_data <= ~conv_data;
        conv_break <= ~conv_break;
        conv_invalid <= ~conv_invalid;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/test_thermocouple_scan_sequencer.sv
// self-checking testbench for the thermocouple scan sequencer
`timescale 1ns/100ps
`default_nettype none
`include "tss_consts.svh"
module test_thermocouple_scan_sequencer;
  // ****************************************
  // short filter counts: code k lasts 34-2k cycles
  // ****************************************
  localparam logic [7:0][23:0] FC = {24'h00_0014, 24'h00_0016, 24'h00_0018, 24'h00_001A,
    24'h00_001C, 24'h00_001E, 24'h00_0020, 24'h00_0022};
  localparam logic [15:0] ID = 16'h3C5A; // arbitrary value
  localparam int SLOT0 = 2 * 34 + 4 + 2; // launch, wait, store; one idle cycle closes a scan
  localparam logic [15:0] EV [6] = '{16'h7FFF, 16'h7FFF, 16'h8001, 16'h8000, 16'h04D2, 16'h03E8};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] lat = 8'h01;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, conv_start, conv_done, conv_break, conv_invalid, error_msg;
  wire logic [2:0] conv_sel;
  wire logic signed [17:0] conv_data;
  int n_fail = 0, num_checks = 0, cyc = 0;
  tss_top #(.ID_CODE(ID), .FILT_CYC(FC), .OVH_CYC(24'h00_0004)) u_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start), .conv_sel(conv_sel),
    .conv_done(conv_done), .conv_data(conv_data), .conv_break(conv_break),
    .conv_invalid(conv_invalid), .error_msg(error_msg));
  tss_front_model u_fe (.hclk(hclk), .hresetn(hresetn), .conv_start(conv_start),
    .conv_sel(conv_sel), .lat(lat), .conv_done(conv_done), .conv_data(conv_data),
    .conv_break(conv_break), .conv_invalid(conv_invalid));
  always #25 hclk = ~hclk;
  // the longest run needs about eight thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer; the address phase is held until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    if (wr) hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(x, e);
  endtask
  task automatic wait_sel(input logic [2:0] s);
    do begin
      @(posedge hclk);
      #1;
    end while (!(conv_start === 1'b1 && conv_sel === s));
  endtask
  // cycles between two launches of slot s, after one launch to settle
  task automatic period(input logic [2:0] s, input int exp);
    time t;
    wait_sel(s);
    wait_sel(s);
    t = $time;
    wait_sel(s);
    check(32'(($time - t) / 50), 32'(exp));
  endtask
  task automatic t_regs();
    rdc(`TSS_A_ENA, 32'h0000_003F);
    rdc(`TSS_A_TYPE, 32'h0000_9249);
    wr(`TSS_A_ID, 32'h0000_FFFF);
    rdc(`TSS_A_ID, {16'h0000, ID});
    rdc(8'h24, 32'h0000_0000);
    rdc(`TSS_A_STHI, 32'h0000_0000);
  endtask
  task automatic t_filter();
    wr(`TSS_A_ENA, 32'h0000_0001);
    for (int k = 0; k < 8; k++) begin
      wr(`TSS_A_CTRL, 32'(k) | 32'h0000_0008);
      period(3'h0, int'(FC[k]) + 3);
    end
  endtask
  task automatic t_model0();
    logic [31:0] a, b;
    lat <= 8'h0C;
    wr(`TSS_A_ENA, 32'h0000_003F);
    wr(`TSS_A_CTRL, 32'h0000_0000);
    period(3'h0, 7 * SLOT0 + 1);
    // the counter is polled once per scan, never in a tighter loop
    wait_sel(3'h0);
    bus(1'b0, `TSS_A_CNT, 32'h0000_0000, a);
    wait_sel(3'h0);
    bus(1'b0, `TSS_A_CNT, 32'h0000_0000, b);
    check((b - a) & 32'h0000_00FF, 32'h0000_0001);
  endtask
  task automatic t_model1();
    wr(`TSS_A_ENA, 32'h0000_0015);
    wr(`TSS_A_CTRL, 32'h0000_0008);
    period(3'h0, 3 * SLOT0 + 1);
    for (int i = 1; i < 4; i++) begin
      do begin
        @(posedge hclk);
        #1;
      end while (conv_start !== 1'b1);
      check(32'(conv_sel), 32'((2 * i) % 6));
    end
  endtask
  task automatic t_faults();
    u_fe.brk[0] = 1'b1;
    u_fe.samp[1] = 18'h0_9C40;
    u_fe.samp[2] = -18'sh0_9C40;
    u_fe.inv[3] = 1'b1;
    u_fe.samp[4] = 18'h0_04D2;
    u_fe.samp[5] = 18'h0_07D0;
    u_fe.samp[6] = 18'h0_00FA;
    wr(`TSS_A_TYPE, 32'h0003_E3B1);
    wr(`TSS_A_ENA, 32'h0000_003F);
    wr(`TSS_A_CTRL, 32'h0000_0000);
    repeat (3) wait_sel(3'h0);
    rdc(`TSS_A_STLO, 32'h0000_001B);
    rdc(`TSS_A_STHI, 32'h0000_0000);
    for (int i = 0; i < 6; i++) rdc(8'(8'h60 + 4 * i), {16'h0000, EV[i]});
    rdc(`TSS_A_TERM, 32'h0000_00FA);
    check(32'(error_msg), 32'h0000_0001);
    wr(`TSS_A_ERR, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    check(32'(error_msg), 32'h0000_0000);
    u_fe.brk[0] = 1'b0;
    u_fe.samp[1] = 18'h0_0064;
    u_fe.samp[2] = 18'h0_0064;
    u_fe.inv[3] = 1'b0;
    repeat (2) wait_sel(3'h0);
    rdc(`TSS_A_STLO, 32'h0000_0000);
    rdc(8'h64, 32'h0000_0064);
    check(32'(error_msg), 32'h0000_0001);
  endtask
  // external junction mode: channels 0 to 2 take their written reference, zero included
  task automatic t_extref();
    wr(8'h40, 32'h0000_00C8);
    wr(8'h44, 32'h0000_012C);
    wr(`TSS_A_TYPE, 32'h0000_925A);
    wr(`TSS_A_CTRL, 32'h0000_0010);
    rdc(`TSS_A_CTRL, 32'h0000_0010);
    rdc(8'h40, 32'h0000_00C8);
    repeat (2) wait_sel(3'h0);
    rdc(8'h60, 32'(((100 * `TSS_G_K) >> 8) + 200));
    rdc(8'h64, 32'(((100 * `TSS_G_S) >> 8) + 300));
    rdc(8'h68, 32'((100 * `TSS_G_J) >> 8));
  endtask
  // main sequence, with a second reset in mid-run at the end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_filter();
    t_model0();
    t_model1();
    t_faults();
    t_extref();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`TSS_A_ENA, 32'h0000_003F);
    rdc(`TSS_A_TYPE, 32'h0000_9249);
    rdc(`TSS_A_CNT, 32'h0000_0000);
    check(32'(error_msg), 32'h0000_0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
